/* inc/sram_host_consts.svh */
`ifndef SRAM_HOST_CONSTS_SVH
`define SRAM_HOST_CONSTS_SVH

// Clock period in picoseconds (100 MHz)
`define CLK_PERIOD_PS        32'd10000
// Device timing figures in picoseconds
`define ADDRESS_ACCESS_PS    32'd29000
`define SELECT_ACCESS_PS     32'd29000
`define ENABLE_ACCESS_PS     32'd29000
`define READ_CYCLE_PS        32'd29000
`define GATE_ACCESS_PS       32'd9000
`define GATE_FLOAT_PS        32'd9000
`define SELECT_FLOAT_PS      32'd10000
`define ENABLE_FLOAT_PS      32'd11000
`define WRITE_PULSE_PS       32'd20000
`define WRITE_CYCLE_PS       32'd25000
`define DATA_SETUP_PS        32'd15000
`define WRITE_RECOVER_PS     32'd5000
`define WRITE_FLOAT_PS       32'd10000
`define WRITE_LOWZ_PS        32'd5000
// Least time to whole cycles, rounded up
`define CYC_MIN(ps) (((ps) + `CLK_PERIOD_PS - 32'd1) / `CLK_PERIOD_PS)
// Reset value of the address and data registers
`define ADDR_RESET           15'h0000
`define DATA_RESET           8'h00

`endif

/* inc/sram_host_pkg.sv */
package sram_host_pkg;

	// Host sequencer states
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_RD_WAIT,
		ST_RD_FLOAT,
		ST_WR_FLOAT,
		ST_WR_PULSE,
		ST_WR_RECOVER
	} host_state_type;

endpackage : sram_host_pkg

/* design/cycle_timer.sv */
`timescale 1ns/1ps
`default_nettype none

// Loadable down counter; done while zero
module cycle_timer #(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input  wire logic             clk_i,
	input  wire logic             rst_b_i,
	input  wire logic             clk_en_i,
	// Control
	input  wire logic             load_i,
	input  wire logic [WIDTH-1:0] count_i,
	output logic                  done_o
);

	logic [WIDTH-1:0] count_reg;

	// Count down to zero, reload on request
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			count_reg <= '0;
		end else if (clk_en_i) begin
			if (load_i) begin
				count_reg <= count_i;
			end else if (count_reg != '0) begin
				count_reg <= count_reg - WIDTH'(1);
			end
		end
	end

	assign done_o = (count_reg == '0);

endmodule : cycle_timer

`default_nettype wire

/* design/sram_host.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sram_host_consts.svh"

module sram_host
	import sram_host_pkg::*;
#(
	parameter int ADDR_WIDTH = 15,
	parameter int DATA_WIDTH = 8,
	parameter int TIMER_WIDTH = 8
) (
	// Clock, reset and enable
	input  wire logic                  clk_i,
	input  wire logic                  rst_b_i,
	input  wire logic                  clk_en_i,
	// User request
	input  wire logic                  req_valid_i,
	input  wire logic                  req_write_i,
	input  wire logic [ADDR_WIDTH-1:0] req_addr_i,
	input  wire logic [DATA_WIDTH-1:0] req_wdata_i,
	output logic                       req_ready_o,
	// User read answer
	output logic                       rsp_valid_o,
	output logic [DATA_WIDTH-1:0]      rsp_rdata_o,
	// Memory pins
	output logic [ADDR_WIDTH-1:0]      addr_o,
	output logic                       select_low_o,
	output logic                       enable_o,
	output logic                       write_strobe_low_o,
	output logic                       output_gate_low_o,
	input  wire logic [DATA_WIDTH-1:0] dq_i,
	output logic [DATA_WIDTH-1:0]      dq_o,
	output logic                       dq_oe_o
);

	// Cycle counts derived from the device figures
	localparam logic [TIMER_WIDTH-1:0] RD_ACCESS_CYC = TIMER_WIDTH'(`CYC_MIN(`ADDRESS_ACCESS_PS));
	localparam logic [TIMER_WIDTH-1:0] RD_FLOAT_CYC  = TIMER_WIDTH'(`CYC_MIN(`GATE_FLOAT_PS));
	localparam logic [TIMER_WIDTH-1:0] WR_FLOAT_CYC  = TIMER_WIDTH'(`CYC_MIN(`WRITE_FLOAT_PS));
	localparam logic [TIMER_WIDTH-1:0] WR_PULSE_CYC  = TIMER_WIDTH'(`CYC_MIN(`WRITE_PULSE_PS));
	localparam logic [TIMER_WIDTH-1:0] WR_RECOV_CYC  = TIMER_WIDTH'(`CYC_MIN(`WRITE_CYCLE_PS - `WRITE_PULSE_PS));

	host_state_type              state_reg;
	host_state_type              state_next;
	logic                        timer_load;
	logic [TIMER_WIDTH-1:0]      timer_count;
	logic                        timer_done;
	logic                        take_req;
	logic [ADDR_WIDTH-1:0]       addr_reg;
	logic [DATA_WIDTH-1:0]       wdata_reg;
	logic                        dq_oe_reg;
	logic                        strobe_low_reg;
	logic                        gate_low_reg;
	logic                        rsp_valid_reg;
	logic [DATA_WIDTH-1:0]       rdata_reg;

	// Phase timer
	cycle_timer #(
		.WIDTH(TIMER_WIDTH)
	) u_timer (
		.clk_i   (clk_i),
		.rst_b_i (rst_b_i),
		.clk_en_i(clk_en_i),
		.load_i  (timer_load),
		.count_i (timer_count),
		.done_o  (timer_done)
	);

	assign take_req    = req_valid_i && req_ready_o;
	assign req_ready_o = (state_reg == ST_IDLE);

	// Next state and timer loads
	always_comb begin
		state_next  = state_reg;
		timer_load  = 1'b0;
		timer_count = '0;
		case (state_reg)
			ST_IDLE: begin
				if (take_req && req_write_i) begin
					state_next  = ST_WR_FLOAT;
					timer_load  = 1'b1;
					timer_count = WR_FLOAT_CYC;
				end else if (take_req) begin
					state_next  = ST_RD_WAIT;
					timer_load  = 1'b1;
					timer_count = RD_ACCESS_CYC;
				end
			end
			ST_RD_WAIT: begin
				if (timer_done) begin
					state_next  = ST_RD_FLOAT;
					timer_load  = 1'b1;
					timer_count = RD_FLOAT_CYC;
				end
			end
			ST_RD_FLOAT: begin
				if (timer_done) begin
					state_next = ST_IDLE;
				end
			end
			ST_WR_FLOAT: begin
				if (timer_done) begin
					state_next  = ST_WR_PULSE;
					timer_load  = 1'b1;
					timer_count = WR_PULSE_CYC;
				end
			end
			ST_WR_PULSE: begin
				if (timer_done) begin
					state_next  = ST_WR_RECOVER;
					timer_load  = 1'b1;
					timer_count = WR_RECOV_CYC;
				end
			end
			ST_WR_RECOVER: begin
				if (timer_done) begin
					state_next = ST_IDLE;
				end
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	// State register
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_reg <= ST_IDLE;
		end else if (clk_en_i) begin
			state_reg <= state_next;
		end
	end

	// Address and write data latch; stable for whole cycle
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			addr_reg  <= `ADDR_RESET;
			wdata_reg <= `DATA_RESET;
		end else if (clk_en_i && take_req) begin
			addr_reg  <= req_addr_i;
			wdata_reg <= req_wdata_i;
		end
	end

	// Write strobe: low only during pulse phase
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			strobe_low_reg <= 1'b1;
		end else if (clk_en_i) begin
			strobe_low_reg <= !(state_next == ST_WR_PULSE);
		end
	end

	// Output gate: low only while reading
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			gate_low_reg <= 1'b1;
		end else if (clk_en_i) begin
			gate_low_reg <= !(state_next == ST_RD_WAIT);
		end
	end

	// Data drive: only while the strobe is low
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			dq_oe_reg <= 1'b0;
		end else if (clk_en_i) begin
			dq_oe_reg <= (state_next == ST_WR_PULSE);
		end
	end

	// Capture read data after access time
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rdata_reg     <= `DATA_RESET;
			rsp_valid_reg <= 1'b0;
		end else if (clk_en_i) begin
			rsp_valid_reg <= 1'b0;
			if (state_reg == ST_RD_WAIT && timer_done) begin
				rdata_reg     <= dq_i;
				rsp_valid_reg <= 1'b1;
			end
		end
	end

	// Select and enable held active; cycles paced by address and strobe
	assign select_low_o       = 1'b0;
	assign enable_o           = 1'b1;
	assign addr_o             = addr_reg;
	assign write_strobe_low_o = strobe_low_reg;
	assign output_gate_low_o  = gate_low_reg;
	assign dq_o               = wdata_reg;
	assign dq_oe_o            = dq_oe_reg;
	assign rsp_valid_o        = rsp_valid_reg;
	assign rsp_rdata_o        = rdata_reg;

endmodule : sram_host

`default_nettype wire

/* tb/sram_host_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module sram_host_sva (
	// Clock and reset
	input wire logic        clk_i,
	input wire logic        rst_b_i,
	// User side
	input wire logic        clk_en_i,
	input wire logic        req_valid_i,
	input wire logic        req_write_i,
	input wire logic        req_ready_o,
	input wire logic        rsp_valid_o,
	// Memory pins
	input wire logic [14:0] addr_o,
	input wire logic        select_low_o,
	input wire logic        enable_o,
	input wire logic        write_strobe_low_o,
	input wire logic        output_gate_low_o,
	input wire logic [7:0]  dq_o,
	input wire logic        dq_oe_o
);
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (!rst_b_i);
	// Read taken, and a three-cycle write pulse
	sequence s_rd_take;
		clk_en_i && req_valid_i && req_ready_o && !req_write_i;
	endsequence
	sequence s_wr_pulse;
		!write_strobe_low_o ##1 !write_strobe_low_o ##1 !write_strobe_low_o;
	endsequence
	a_read_gate_low: assert property (s_rd_take |=> !output_gate_low_o) else $error("gate idle after read");
	a_read_answer: assert property (s_rd_take |-> ##5 rsp_valid_o) else $error("read answer late");
	a_busy_refuse: assert property (s_rd_take |=> !req_ready_o [*3]) else $error("ready during read");
	a_addr_settled: assert property ($rose(rsp_valid_o) |-> !$past(output_gate_low_o)
		&& $past(addr_o) == $past(addr_o, 3)) else $error("data sampled early");
	a_float_first: assert property ($rose(dq_oe_o) |-> $past(output_gate_low_o)
		&& $past(output_gate_low_o, 2)) else $error("drive before float");
	a_pulse_width: assert property ($fell(write_strobe_low_o) |-> s_wr_pulse ##1 write_strobe_low_o [*3])
		else $error("write pulse timing");
	a_data_held: assert property (!write_strobe_low_o |-> dq_oe_o && $stable(dq_o) && $stable(addr_o))
		else $error("write data or address moved");
	a_gate_in_write: assert property (!write_strobe_low_o |-> output_gate_low_o) else $error("gate low in write");
	a_always_sel: assert property (!select_low_o && enable_o) else $error("device deselected");
endmodule : sram_host_sva
bind sram_host sram_host_sva i_sva (.clk_i(clk_i), .rst_b_i(rst_b_i), .clk_en_i(clk_en_i),
	.req_valid_i(req_valid_i), .req_write_i(req_write_i), .req_ready_o(req_ready_o),
	.rsp_valid_o(rsp_valid_o), .addr_o(addr_o), .select_low_o(select_low_o), .enable_o(enable_o),
	.write_strobe_low_o(write_strobe_low_o), .output_gate_low_o(output_gate_low_o),
	.dq_o(dq_o), .dq_oe_o(dq_oe_o));
`default_nettype wire

/* tb/sram_model.sv */
`timescale 1ns/1ps
`default_nettype none
module sram_model (
	// Control and address
	input  wire logic [14:0] addr_i,
	input  wire logic        select_low_i,
	input  wire logic        enable_i,
	input  wire logic        write_strobe_low_i,
	input  wire logic        output_gate_low_i,
	// Data port
	input  wire logic [7:0]  din_i,
	input  wire logic        din_oe_i,
	output logic [7:0]       q_o,
	output logic             drv_o
);
	logic [7:0] mem [0:32767];
	logic [7:0] rd = 8'h00;
	logic [7:0] wdat = 8'h00;
	logic       gv = 1'b0;
	logic       wr;
	// Write window is the overlap of all three
	assign wr = !write_strobe_low_i && !select_low_i && enable_i;
	// Old data lasts 3 ns, new data after access time
	always @(addr_i) begin
		rd <= #3 ~rd;
		rd <= #29 mem[addr_i];
	end
	// Data seen while the host drives in the window
	always @* begin
		if (wr && din_oe_i) wdat = din_i;
	end
	// Store at end of write
	always @(negedge wr) begin
		mem[addr_i] = wdat;
		rd <= #29 wdat;
	end
	// Gate access delay before data shows
	always @(output_gate_low_i) begin
		gv = 1'b0;
		if (!output_gate_low_i) gv <= #9 1'b1;
	end
	// Drivers on for a gated read only
	assign drv_o = !output_gate_low_i && !select_low_i && enable_i && write_strobe_low_i;
	assign q_o = gv ? rd : ~rd;
endmodule : sram_model
`default_nettype wire

/* tb/async_static_ram_port_test.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_count++; $display("[FAIL] %0t mismatch", $time); end end
module async_static_ram_port_test;
	logic        clk_i = 1'b0;
	logic        rst_b_i = 1'b0;
	logic        clk_en_i = 1'b1;
	logic        req_valid_i = 1'b0;
	logic        req_write_i = 1'b0;
	logic [14:0] req_addr_i = 15'h0000;
	logic [7:0]  req_wdata_i = 8'h00;
	logic        req_ready_o, rsp_valid_o, select_low_o, enable_o, write_strobe_low_o, output_gate_low_o, dq_oe_o, drv;
	logic [7:0]  rsp_rdata_o, dq_o, q, dq_i;
	logic [14:0] addr_o;
	int          err_count = 0;
	int          total_checks = 0;
	logic [14:0] at [4] = '{15'h0000, 15'h7FFF, 15'h4000, 15'h0001};
	logic [7:0]  dt [4] = '{8'hA5, 8'h5A, 8'hFF, 8'h00};
	// Bus level; released bus shows inverted data
	assign dq_i = dq_oe_o ? dq_o : (drv ? q : ~q);
	sram_host i_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .clk_en_i(clk_en_i), .req_valid_i(req_valid_i),
		.req_write_i(req_write_i), .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i), .req_ready_o(req_ready_o),
		.rsp_valid_o(rsp_valid_o), .rsp_rdata_o(rsp_rdata_o), .addr_o(addr_o), .select_low_o(select_low_o),
		.enable_o(enable_o), .write_strobe_low_o(write_strobe_low_o), .output_gate_low_o(output_gate_low_o),
		.dq_i(dq_i), .dq_o(dq_o), .dq_oe_o(dq_oe_o));
	sram_model i_mem (.addr_i(addr_o), .select_low_i(select_low_o), .enable_i(enable_o),
		.write_strobe_low_i(write_strobe_low_o), .output_gate_low_i(output_gate_low_o),
		.din_i(dq_o), .din_oe_i(dq_oe_o), .q_o(q), .drv_o(drv));
	// Clock
	initial forever #5 clk_i = ~clk_i;
	// One request, held until taken; starts one edge after the caller
	task automatic req(input logic w, input logic [14:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(negedge clk_i);
		req_valid_i = 1'b1;
		req_write_i = w;
		req_addr_i = a;
		req_wdata_i = d;
		while (req_ready_o !== 1'b1 && n < 20) begin
			@(negedge clk_i);
			n++;
		end
		`CHK(req_ready_o, 1'b1)
		@(negedge clk_i);
		req_valid_i = 1'b0;
	endtask : req
	// Read and compare, with latency
	task automatic rd(input logic [14:0] a, input logic [7:0] e);
		int n;
		n = 0;
		req(1'b0, a, 8'h00);
		while (rsp_valid_o !== 1'b1 && n < 20) begin
			@(negedge clk_i);
			n++;
		end
		`CHK(n, 4)
		`CHK(rsp_rdata_o, e)
		@(negedge clk_i);
		`CHK(rsp_valid_o, 1'b0)
	endtask : rd
	task automatic t_reset;
		`CHK({req_ready_o, write_strobe_low_o, output_gate_low_o, dq_oe_o, rsp_valid_o}, 5'b11100)
		`CHK(addr_o, 15'h0000)
	endtask : t_reset
	// Edge addresses, back to back
	task automatic t_fill;
		for (int i = 0; i < 4; i++) req(1'b1, at[i], dt[i]);
		for (int i = 0; i < 4; i++) rd(at[i], dt[i]);
	endtask : t_fill
	// Rewrite and reread with no address change
	task automatic t_same;
		req(1'b1, 15'h2222, 8'h3C);
		rd(15'h2222, 8'h3C);
		req(1'b1, 15'h2222, 8'hC3);
		rd(15'h2222, 8'hC3);
		rd(15'h2222, 8'hC3);
	endtask : t_same
	// Low clock enable keeps a pending read from starting
	task automatic t_freeze;
		@(negedge clk_i);
		clk_en_i = 1'b0;
		req_valid_i = 1'b1;
		req_write_i = 1'b0;
		req_addr_i = 15'h5555;
		repeat (3) @(negedge clk_i);
		`CHK({addr_o, output_gate_low_o, rsp_valid_o}, {15'h2222, 2'b10})
		req_valid_i = 1'b0;
		@(negedge clk_i);
		clk_en_i = 1'b1;
		rd(15'h2222, 8'hC3);
	endtask : t_freeze
	task automatic results;
		if (err_count == 0 && total_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : results
	// Main sequence
	initial begin
		repeat (16) @(negedge clk_i);
		rst_b_i = 1'b1;
		@(negedge clk_i);
		t_reset();
		t_fill();
		t_same();
		t_freeze();
		results();
	end
	// Watchdog
	initial begin
		#20us;
		err_count++;
		results();
	end
endmodule : async_static_ram_port_test
`default_nettype wire
